//--- core/door_ctrl_params.svh
`ifndef DOOR_CTRL_PARAMS_SVH
`define DOOR_CTRL_PARAMS_SVH

// register addresses on the serial command port
`define BUS_AND_MASK_CONTROL_ADDR 6'h26
`define BRIDGE_PWM_AND_PUMP_CONTROL_ADDR 6'h27
`define THERMAL_AND_CONSTANT_CURRENT_CONTROL_ADDR 6'h2c

// reset values
`define BUS_AND_MASK_CONTROL_RESET 24'h400088
`define BRIDGE_PWM_AND_PUMP_CONTROL_RESET 24'h000000
`define THERMAL_AND_CONSTANT_CURRENT_CONTROL_RESET 24'h000000

// implemented bits; all others are reserved and read zero
`define BUS_AND_MASK_CONTROL_MASK 24'he72f9f
`define BRIDGE_PWM_AND_PUMP_CONTROL_MASK 24'h00003e
`define THERMAL_AND_CONSTANT_CURRENT_CONTROL_MASK 24'h1021f7

// first control register fields
`define CAN_LOOP_BIT 23
`define LIN_STUCK_TRANSMIT_DETECT_BIT 22
`define LIN_WAKE_CONDITION_SELECT_BIT 21
`define PUMP_DITHER_DISABLE_BIT 18
`define LOAD_SUPERVISION_UNLOCK_BIT 17
`define WATCHDOG_SETTING_UNLOCK_BIT 16
`define THERMAL_WARNING_MASK_BIT 13
`define OPEN_LOAD_MASK_BIT 11
`define INTERFACE_ERROR_MASK_BIT 10
`define PHYS_LAYER_ERROR_MASK_BIT 9
`define WARNING_SUMMARY_MASK_BIT 8
`define PUMP_OFF_UNLOCK_BIT 7
`define CAN_AUTO_BIAS_BIT 4
`define FIRST_DIRECTION_SELECT_BIT 3
`define SECONDARY_REGULATOR_HI 2
`define SECONDARY_REGULATOR_LO 1
`define WATCHDOG_TRIGGER_BIT 0

// second control register fields
`define BRIDGE_SIX_PWM_ENABLE_BIT 5
`define SHARED_BRIDGE_PWM_ROUTE_HI 4
`define SHARED_BRIDGE_PWM_ROUTE_LO 3
`define PUMP_OFF_BIT 2
`define LOAD_SUPERVISION_DISABLE_BIT 1

// third control register fields
`define THERMAL_CLUSTER_ENABLE_BIT 20

// global status byte positions (bits 31..24 of the status word)
`define GSB_GLOBAL_ERROR 7
`define GSB_INTERFACE_ERROR 5
`define GSB_PHYS_LAYER_ERROR 4
`define GSB_FUNCTIONAL_ERROR 3
`define GSB_GLOBAL_WARNING 1

// timing
`define CLOCK_MHZ 200
`define LIN_WAKE_DOMINANT_NS 28000
`define LIN_WAKE_DOMINANT_CYCLES ((`LIN_WAKE_DOMINANT_NS * `CLOCK_MHZ + 999) / 1000)

`endif

//--- core/door_ctrl_pkg.sv
package door_ctrl_pkg;

	typedef enum logic [1:0] {
		mode_active,
		mode_regulator_standby,
		mode_battery_standby
	} power_mode_t;

	typedef enum logic [1:0] {
		route_none,
		route_bridge_four,
		route_bridge_five,
		route_both
	} shared_route_t;

	typedef enum {
		wake_idle,
		wake_dominant
	} wake_state_t;

endpackage

//--- core/status_summary_if.sv
`timescale 1ns/1ps
`default_nettype none

interface status_summary_if;
	logic thermal_warning_mask;
	logic open_load_mask;
	logic interface_error_mask;
	logic phys_layer_error_mask;
	logic warning_summary_mask;
	logic thermal_warning;
	logic open_load;
	logic interface_error;
	logic phys_layer_error;
	logic warning_condition;
	logic [7:0] global_status_byte;

	modport ctrl (
		output thermal_warning_mask,
		output open_load_mask,
		output interface_error_mask,
		output phys_layer_error_mask,
		output warning_summary_mask,
		output thermal_warning,
		output open_load,
		output interface_error,
		output phys_layer_error,
		output warning_condition,
		input global_status_byte
	);

	modport summary (
		input thermal_warning_mask,
		input open_load_mask,
		input interface_error_mask,
		input phys_layer_error_mask,
		input warning_summary_mask,
		input thermal_warning,
		input open_load,
		input interface_error,
		input phys_layer_error,
		input warning_condition,
		output global_status_byte
	);
endinterface

`default_nettype wire

//--- core/status_summary.sv
`timescale 1ns/1ps
`default_nettype none
`include "door_ctrl_params.svh"

module status_summary (
	input wire logic core_clk,
	input wire logic rst,
	status_summary_if.summary st
);
	logic [7:0] next_gsb;

	always_comb begin
		next_gsb = 8'h00;
		next_gsb[`GSB_GLOBAL_WARNING] = st.thermal_warning | st.warning_condition;
		next_gsb[`GSB_FUNCTIONAL_ERROR] = st.open_load;
		next_gsb[`GSB_PHYS_LAYER_ERROR] = st.phys_layer_error;
		next_gsb[`GSB_INTERFACE_ERROR] = st.interface_error;
		next_gsb[`GSB_GLOBAL_ERROR] = (st.thermal_warning & ~st.thermal_warning_mask)
			| (st.open_load & ~st.open_load_mask)
			| (st.interface_error & ~st.interface_error_mask)
			| (st.phys_layer_error & ~st.phys_layer_error_mask)
			| (st.warning_condition & ~st.warning_summary_mask);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st.global_status_byte <= 8'h00;
		end else begin
			st.global_status_byte <= next_gsb;
		end
	end
endmodule

`default_nettype wire

//--- core/lin_wake_detect.sv
`timescale 1ns/1ps
`default_nettype none

module lin_wake_detect #(
	parameter int DOMINANT_CYCLES = 5600
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic lin_rx_sync,
	input wire logic edge_only,
	output logic lin_wake
);
	localparam int CW = $clog2(DOMINANT_CYCLES + 1);

	door_ctrl_pkg::wake_state_t state;
	logic [CW-1:0] dom_count;
	logic rx_prev;

	generate
		if (DOMINANT_CYCLES < 1) begin : g_bad
			$error("lin_wake_detect: DOMINANT_CYCLES must be at least one");
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_prev <= 1'b1;
		end else begin
			rx_prev <= lin_rx_sync;
		end
	end

	// bus high is recessive, low is dominant
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= door_ctrl_pkg::wake_idle;
			dom_count <= '0;
			lin_wake <= 1'b0;
		end else begin
			lin_wake <= 1'b0;
			case (state)
				door_ctrl_pkg::wake_idle: begin
					dom_count <= '0;
					if (rx_prev && !lin_rx_sync) begin
						if (edge_only) begin
							lin_wake <= 1'b1;
						end else begin
							state <= door_ctrl_pkg::wake_dominant;
						end
					end
				end
				door_ctrl_pkg::wake_dominant: begin
					if (lin_rx_sync) begin
						state <= door_ctrl_pkg::wake_idle;
						lin_wake <= (dom_count >= CW'(DOMINANT_CYCLES));
					end else if (dom_count < CW'(DOMINANT_CYCLES)) begin
						dom_count <= dom_count + CW'(1);
					end
				end
				default: begin
					state <= door_ctrl_pkg::wake_idle;
				end
			endcase
		end
	end
endmodule

`default_nettype wire

//--- core/door_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "door_ctrl_params.svh"

// What this block does
// - Control bit 23 set loops CAN transmit input to receive output; resets off.
// - Bit 22 enables stuck LIN transmit timeout detection; resets enabled.
// - Bit 21 clear: wake on dominant pulse over 28 us; set: falling edge.
// - Bit 18 set disables charge pump dithering; resets to dithering on.
// - Without load supervision unlock, writing one to its disable bit is ignored.
// - Unlock allows the disable write in the next command only, then clears.
// - Watchdog setting unlock opens the next command only, then clears itself.
// - Thermal warning mask keeps warnings out of the global error flag.
// - Open load mask keeps open load out of global error, functional flag stays.
// - Interface error mask keeps interface errors out of global error.
// - Physical layer mask keeps those errors out of global error.
// - Warning summary mask keeps warnings out of global error; masks reset clear.
// - Pump off unlock clear refuses writing one to pump off; resets set.
// - Bit 4 enables CAN automatic biasing; resets off.
// - Bit 3 routes shared input to first direction or second wake input.
// - Bits 2:1 pick secondary regulator on-modes: off, active, active plus regulator standby.
// - Second register bit 5 puts channel six PWM on bridge six low side.
// - Bits 4:3 route shared PWM to bridge four, five, both or none.
// - Second register bit 2 switches pump off, settable only while unlocked.
// - Second register bit 1 disables load supervision, settable only while unlocked.
// - Third register bit 20 enables per-cluster thermal warning and shutdown.
// - Third register holds per-output constant current start-up enables.
// - Global status has error summary, warning and three error class flags.
module door_ctrl_regs #(
	parameter int LIN_WAKE_CYCLES = `LIN_WAKE_DOMINANT_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	// decoded serial command, one pulse per finished frame
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [5:0] cmd_addr,
	input wire logic [23:0] cmd_wdata,
	output logic [23:0] cmd_rdata,
	output logic cmd_hit,
	// transceiver paths
	input wire logic can_transmit_input,
	input wire logic can_transceiver_rx,
	output logic can_receive_output,
	input wire logic lin_bus_rx,
	output logic lin_wake,
	// shared input pin and PWM sources
	input wire logic shared_input_pin,
	output logic first_direction_input,
	output logic second_external_wake_input,
	output logic second_direction_enable,
	input wire logic pwm_shared,
	input wire logic pwm_six,
	output logic half_bridge_four_ls_pwm,
	output logic half_bridge_five_ls_pwm,
	output logic half_bridge_six_ls_pwm,
	// power mode and regulator
	input wire door_ctrl_pkg::power_mode_t power_mode,
	output logic secondary_regulator_on,
	// configuration levels to the rest of the device
	output logic lin_stuck_transmit_detect,
	output logic pump_dither_disable,
	output logic pump_off,
	output logic can_auto_bias,
	output logic load_supervision_disable,
	output logic watchdog_setting_unlock,
	output logic watchdog_trigger,
	output logic thermal_cluster_enable,
	output logic [8:0] high_side_const_current_enable,
	// fault levels and the resulting global status
	input wire logic thermal_warning,
	input wire logic open_load,
	input wire logic interface_error,
	input wire logic phys_layer_error,
	input wire logic warning_condition,
	output logic [7:0] global_status_byte
);
	logic [23:0] bus_and_mask_control;
	logic [23:0] bridge_pwm_and_pump_control;
	logic [23:0] thermal_and_constant_current_control;
	logic [23:0] next_bus_and_mask_control;
	logic [23:0] next_bridge_pwm_and_pump_control;
	logic wr_cr1;
	logic wr_cr2;
	logic wr_cr3;
	logic [1:0] can_tx_sync;
	logic [1:0] lin_sync;
	logic [1:0] shared_sync;
	door_ctrl_pkg::shared_route_t route;

	status_summary_if st ();

	// the wake counter needs a threshold of at least one cycle
	generate
		if (LIN_WAKE_CYCLES < 1) begin : g_bad_wake
			$error("LIN_WAKE_CYCLES below one");
		end
	endgenerate

	function automatic logic addr_is(input logic [5:0] a, input logic [5:0] target);
		return a == target;
	endfunction

	function automatic logic guarded_bit(input logic old_v, input logic new_v, input logic unlocked);
		// a one is only taken when unlocked; clearing is always allowed
		return new_v ? (unlocked | old_v) : 1'b0;
	endfunction

	always_comb begin
		wr_cr1 = cmd_valid & cmd_write & addr_is(cmd_addr, `BUS_AND_MASK_CONTROL_ADDR);
		wr_cr2 = cmd_valid & cmd_write & addr_is(cmd_addr, `BRIDGE_PWM_AND_PUMP_CONTROL_ADDR);
		wr_cr3 = cmd_valid & cmd_write & addr_is(cmd_addr, `THERMAL_AND_CONSTANT_CURRENT_CONTROL_ADDR);
	end

	// first control register, including self-clearing unlock bits
	always_comb begin
		next_bus_and_mask_control = bus_and_mask_control;
		if (wr_cr1) begin
			next_bus_and_mask_control = cmd_wdata & `BUS_AND_MASK_CONTROL_MASK;
		end else if (cmd_valid) begin
			// any other command consumes the one-shot unlocks
			next_bus_and_mask_control[`LOAD_SUPERVISION_UNLOCK_BIT] = 1'b0;
			next_bus_and_mask_control[`WATCHDOG_SETTING_UNLOCK_BIT] = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			bus_and_mask_control <= `BUS_AND_MASK_CONTROL_RESET;
		end else begin
			bus_and_mask_control <= next_bus_and_mask_control;
		end
	end

	// second control register with guarded bits
	always_comb begin
		next_bridge_pwm_and_pump_control = bridge_pwm_and_pump_control;
		if (wr_cr2) begin
			next_bridge_pwm_and_pump_control = cmd_wdata & `BRIDGE_PWM_AND_PUMP_CONTROL_MASK;
			next_bridge_pwm_and_pump_control[`PUMP_OFF_BIT] = guarded_bit(
				bridge_pwm_and_pump_control[`PUMP_OFF_BIT], cmd_wdata[`PUMP_OFF_BIT],
				bus_and_mask_control[`PUMP_OFF_UNLOCK_BIT]);
			next_bridge_pwm_and_pump_control[`LOAD_SUPERVISION_DISABLE_BIT] = guarded_bit(
				bridge_pwm_and_pump_control[`LOAD_SUPERVISION_DISABLE_BIT],
				cmd_wdata[`LOAD_SUPERVISION_DISABLE_BIT],
				bus_and_mask_control[`LOAD_SUPERVISION_UNLOCK_BIT]);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			bridge_pwm_and_pump_control <= `BRIDGE_PWM_AND_PUMP_CONTROL_RESET;
		end else begin
			bridge_pwm_and_pump_control <= next_bridge_pwm_and_pump_control;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			thermal_and_constant_current_control <= `THERMAL_AND_CONSTANT_CURRENT_CONTROL_RESET;
		end else if (wr_cr3) begin
			thermal_and_constant_current_control <= cmd_wdata & `THERMAL_AND_CONSTANT_CURRENT_CONTROL_MASK;
		end
	end

	// read back: value before this command's write, unmapped reads zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cmd_rdata <= 24'h000000;
			cmd_hit <= 1'b0;
		end else if (cmd_valid) begin
			cmd_hit <= addr_is(cmd_addr, `BUS_AND_MASK_CONTROL_ADDR)
				| addr_is(cmd_addr, `BRIDGE_PWM_AND_PUMP_CONTROL_ADDR)
				| addr_is(cmd_addr, `THERMAL_AND_CONSTANT_CURRENT_CONTROL_ADDR);
			if (addr_is(cmd_addr, `BUS_AND_MASK_CONTROL_ADDR)) begin
				cmd_rdata <= bus_and_mask_control;
			end else if (addr_is(cmd_addr, `BRIDGE_PWM_AND_PUMP_CONTROL_ADDR)) begin
				cmd_rdata <= bridge_pwm_and_pump_control;
			end else if (addr_is(cmd_addr, `THERMAL_AND_CONSTANT_CURRENT_CONTROL_ADDR)) begin
				cmd_rdata <= thermal_and_constant_current_control;
			end else begin
				cmd_rdata <= 24'h000000;
			end
		end
	end

	// pin synchronisers: two flops each for the CAN transmit, LIN and shared input pins before logic reads them
	always_ff @(posedge core_clk) begin
		if (rst) begin
			can_tx_sync <= 2'h3;
			lin_sync <= 2'h3;
			shared_sync <= 2'h0;
		end else begin
			can_tx_sync <= {can_tx_sync[0], can_transmit_input};
			lin_sync <= {lin_sync[0], lin_bus_rx};
			shared_sync <= {shared_sync[0], shared_input_pin};
		end
	end

	// receive path: loop the transmit data back while looping is on
	always_ff @(posedge core_clk) begin
		if (rst) begin
			can_receive_output <= 1'b1;
		end else if (bus_and_mask_control[`CAN_LOOP_BIT]) begin
			can_receive_output <= can_tx_sync[1];
		end else begin
			can_receive_output <= can_transceiver_rx;
		end
	end

	lin_wake_detect #(
		.DOMINANT_CYCLES(LIN_WAKE_CYCLES)
	) u_lin_wake (
		.core_clk(core_clk),
		.rst(rst),
		.lin_rx_sync(lin_sync[1]),
		.edge_only(bus_and_mask_control[`LIN_WAKE_CONDITION_SELECT_BIT]),
		.lin_wake(lin_wake)
	);

	// shared input pin function
	always_ff @(posedge core_clk) begin
		if (rst) begin
			first_direction_input <= 1'b0;
			second_external_wake_input <= 1'b0;
		end else begin
			first_direction_input <= bus_and_mask_control[`FIRST_DIRECTION_SELECT_BIT] & shared_sync[1];
			second_external_wake_input <= ~bus_and_mask_control[`FIRST_DIRECTION_SELECT_BIT] & shared_sync[1];
		end
	end

	// low-side PWM steering
	always_comb begin
		route = door_ctrl_pkg::shared_route_t'(bridge_pwm_and_pump_control[`SHARED_BRIDGE_PWM_ROUTE_HI:`SHARED_BRIDGE_PWM_ROUTE_LO]);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			half_bridge_four_ls_pwm <= 1'b0;
			half_bridge_five_ls_pwm <= 1'b0;
			half_bridge_six_ls_pwm <= 1'b0;
		end else begin
			half_bridge_four_ls_pwm <= pwm_shared & (route == door_ctrl_pkg::route_bridge_four
				|| route == door_ctrl_pkg::route_both);
			half_bridge_five_ls_pwm <= pwm_shared & (route == door_ctrl_pkg::route_bridge_five
				|| route == door_ctrl_pkg::route_both);
			half_bridge_six_ls_pwm <= pwm_six & bridge_pwm_and_pump_control[`BRIDGE_SIX_PWM_ENABLE_BIT];
		end
	end

	// secondary regulator enable per power mode
	always_ff @(posedge core_clk) begin
		if (rst) begin
			secondary_regulator_on <= 1'b0;
		end else begin
			case (bus_and_mask_control[`SECONDARY_REGULATOR_HI:`SECONDARY_REGULATOR_LO])
				2'h0: secondary_regulator_on <= 1'b0;
				2'h1: secondary_regulator_on <= (power_mode == door_ctrl_pkg::mode_active);
				default: secondary_regulator_on <= (power_mode != door_ctrl_pkg::mode_battery_standby);
			endcase
		end
	end

	always_comb begin
		second_direction_enable = ~bridge_pwm_and_pump_control[`BRIDGE_SIX_PWM_ENABLE_BIT];
		lin_stuck_transmit_detect = bus_and_mask_control[`LIN_STUCK_TRANSMIT_DETECT_BIT];
		pump_dither_disable = bus_and_mask_control[`PUMP_DITHER_DISABLE_BIT];
		pump_off = bridge_pwm_and_pump_control[`PUMP_OFF_BIT];
		can_auto_bias = bus_and_mask_control[`CAN_AUTO_BIAS_BIT];
		load_supervision_disable = bridge_pwm_and_pump_control[`LOAD_SUPERVISION_DISABLE_BIT];
		watchdog_setting_unlock = bus_and_mask_control[`WATCHDOG_SETTING_UNLOCK_BIT];
		watchdog_trigger = bus_and_mask_control[`WATCHDOG_TRIGGER_BIT];
		thermal_cluster_enable = thermal_and_constant_current_control[`THERMAL_CLUSTER_ENABLE_BIT];
		high_side_const_current_enable = {thermal_and_constant_current_control[13],
			thermal_and_constant_current_control[8:4], thermal_and_constant_current_control[2:0]};
	end

	// fault summary
	always_comb begin
		st.thermal_warning_mask = bus_and_mask_control[`THERMAL_WARNING_MASK_BIT];
		st.open_load_mask = bus_and_mask_control[`OPEN_LOAD_MASK_BIT];
		st.interface_error_mask = bus_and_mask_control[`INTERFACE_ERROR_MASK_BIT];
		st.phys_layer_error_mask = bus_and_mask_control[`PHYS_LAYER_ERROR_MASK_BIT];
		st.warning_summary_mask = bus_and_mask_control[`WARNING_SUMMARY_MASK_BIT];
		st.thermal_warning = thermal_warning;
		st.open_load = open_load;
		st.interface_error = interface_error;
		st.phys_layer_error = phys_layer_error;
		st.warning_condition = warning_condition;
		global_status_byte = st.global_status_byte;
	end

	status_summary u_summary (
		.core_clk(core_clk),
		.rst(rst),
		.st(st.summary)
	);
endmodule

`default_nettype wire

//--- tb/door_ctrl_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module door_ctrl_regs_monitor (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [5:0] cmd_addr,
	input wire logic [23:0] cmd_wdata,
	input wire logic can_transceiver_rx,
	input wire logic can_receive_output,
	input wire logic pwm_shared,
	input wire logic pwm_six,
	input wire logic half_bridge_four_ls_pwm,
	input wire logic half_bridge_six_ls_pwm,
	input wire door_ctrl_pkg::power_mode_t power_mode,
	input wire logic secondary_regulator_on,
	input wire logic pump_off,
	input wire logic load_supervision_disable,
	input wire logic watchdog_setting_unlock,
	input wire logic thermal_warning,
	input wire logic open_load,
	input wire logic interface_error,
	input wire logic phys_layer_error,
	input wire logic warning_condition,
	input wire logic [7:0] global_status_byte
);
	logic [23:0] sh1;
	logic [1:0] sh2;
	logic cr1_wr;
	logic err_now;
	logic reg_now;
	// shadow of the first register and of second register bits 5 and 3, rebuilt from the command stream
	assign cr1_wr = cmd_valid && cmd_write && cmd_addr == 6'h26;
	assign err_now = (thermal_warning && !sh1[13]) || (open_load && !sh1[11]) || (interface_error && !sh1[10])
		|| (phys_layer_error && !sh1[9]) || (warning_condition && !sh1[8]);
	assign reg_now = (sh1[2:1] == 2'h1 && power_mode == door_ctrl_pkg::mode_active)
		|| (sh1[2] && power_mode != door_ctrl_pkg::mode_battery_standby);
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sh1 <= 24'h400088;
		end else if (cr1_wr) begin
			sh1 <= cmd_wdata & 24'he72f9f;
		end else if (cmd_valid) begin
			sh1[17:16] <= 2'h0;
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sh2 <= 2'h0;
		end else if (cmd_valid && cmd_write && cmd_addr == 6'h27) begin
			sh2 <= {cmd_wdata[5], cmd_wdata[3]};
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence other_cmd;
		cmd_valid && !cr1_wr;
	endsequence
	sequence open_unlock;
		watchdog_setting_unlock;
	endsequence
	unlock_expire_a: assert property (open_unlock ##0 other_cmd |=> !watchdog_setting_unlock)
		else $error("watchdog unlock survived a second command");
	unlock_load_a: assert property (cr1_wr |=> watchdog_setting_unlock == $past(cmd_wdata[16]))
		else $error("watchdog unlock not loaded by register write");
	refuse_disable_a: assert property ($rose(load_supervision_disable) |->
		$past(cmd_valid && cmd_write && cmd_addr == 6'h27 && cmd_wdata[1] && sh1[17]))
		else $error("supervision disable set without unlock");
	refuse_pump_a: assert property ($rose(pump_off) |->
		$past(cmd_valid && cmd_write && cmd_addr == 6'h27 && cmd_wdata[2] && sh1[7]))
		else $error("pump off set without unlock");
	error_summary_a: assert property (!$past(rst) |-> global_status_byte[7] == $past(err_now))
		else $error("global error flag wrong");
	class_flags_a: assert property (!$past(rst) |->
		global_status_byte[5:3] == $past({interface_error, phys_layer_error, open_load}))
		else $error("error class flags wrong");
	bridge_route_a: assert property (!$past(rst) |-> half_bridge_four_ls_pwm == $past(pwm_shared && sh2[0])
		&& half_bridge_six_ls_pwm == $past(pwm_six && sh2[1]))
		else $error("low side pwm routing wrong");
	regulator_modes_a: assert property (!$past(rst) |-> secondary_regulator_on == $past(reg_now))
		else $error("secondary regulator state wrong");
	can_path_a: assert property (!$past(rst) && !$past(sh1[23]) |->
		can_receive_output == $past(can_transceiver_rx))
		else $error("can receive output not following transceiver");
endmodule
bind door_ctrl_regs door_ctrl_regs_monitor i_monitor (.core_clk, .rst,
	.cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata, .can_transceiver_rx, .can_receive_output, .pwm_shared,
	.pwm_six, .half_bridge_four_ls_pwm, .half_bridge_six_ls_pwm, .power_mode, .secondary_regulator_on,
	.pump_off, .load_supervision_disable, .watchdog_setting_unlock, .thermal_warning, .open_load,
	.interface_error, .phys_layer_error, .warning_condition, .global_status_byte);
`default_nettype wire

//--- tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic core_clk,
	output logic cmd_valid,
	output logic cmd_write,
	output logic [5:0] cmd_addr,
	output logic [23:0] cmd_wdata
);
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_addr = 6'h0;
		cmd_wdata = 24'h0;
	end
	// gap makes a slow host; released lines carry the inverse so stale values never look current
	task automatic issue(input logic w, input logic [5:0] a, input logic [23:0] d, input int gap);
		repeat (gap) @(posedge core_clk);
		@(posedge core_clk);
		#1;
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_addr = a;
		cmd_wdata = d;
		@(posedge core_clk);
		#1;
		cmd_valid = 1'b0;
		cmd_write = ~w;
		cmd_addr = ~a;
		cmd_wdata = ~d;
	endtask
endmodule
`default_nettype wire

//--- tb/door_ctrl_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module door_ctrl_regs_bench;
	logic core_clk, rst, cmd_valid, cmd_write, cmd_hit, can_transmit_input, can_transceiver_rx, can_receive_output;
	logic lin_bus_rx, lin_wake, shared_input_pin, first_direction_input, second_external_wake_input;
	logic second_direction_enable, pwm_shared, pwm_six, half_bridge_four_ls_pwm, half_bridge_five_ls_pwm;
	logic half_bridge_six_ls_pwm, secondary_regulator_on, lin_stuck_transmit_detect, pump_dither_disable, pump_off;
	logic can_auto_bias, load_supervision_disable, watchdog_setting_unlock, watchdog_trigger, thermal_cluster_enable;
	logic thermal_warning, open_load, interface_error, phys_layer_error, warning_condition;
	logic [5:0] cmd_addr;
	logic [23:0] cmd_wdata, cmd_rdata, m1, m2, m3, exp, d;
	logic [8:0] high_side_const_current_enable;
	logic [7:0] global_status_byte;
	logic [31:0] seed, r;
	logic [30:0] seq [11];
	door_ctrl_pkg::power_mode_t power_mode;
	int mismatches, n_checks;
	host_model i_host (.core_clk, .cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata);
	door_ctrl_regs #(.LIN_WAKE_CYCLES(8)) i_dut (.core_clk, .rst, .cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata,
		.cmd_rdata, .cmd_hit, .can_transmit_input, .can_transceiver_rx, .can_receive_output, .lin_bus_rx, .lin_wake,
		.shared_input_pin, .first_direction_input, .second_external_wake_input, .second_direction_enable,
		.pwm_shared, .pwm_six, .half_bridge_four_ls_pwm, .half_bridge_five_ls_pwm, .half_bridge_six_ls_pwm,
		.power_mode, .secondary_regulator_on, .lin_stuck_transmit_detect, .pump_dither_disable, .pump_off,
		.can_auto_bias, .load_supervision_disable, .watchdog_setting_unlock, .watchdog_trigger,
		.thermal_cluster_enable, .high_side_const_current_enable, .thermal_warning, .open_load, .interface_error,
		.phys_layer_error, .warning_condition, .global_status_byte);
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task chk_word(input logic [23:0] got, input logic [23:0] expv);
		n_checks++;
		if (got !== expv) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, expv);
		end
	endtask
	task chk_bit(input logic got, input logic expv);
		n_checks++;
		if (got !== expv) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, expv);
		end
	endtask
	task conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task do_cmd(input logic w, input logic [5:0] a, input logic [23:0] dv);
		logic u17, u7;
		u17 = m1[17];
		u7 = m1[7];
		exp = (a == 6'h26) ? m1 : (a == 6'h27) ? m2 : (a == 6'h2c) ? m3 : 24'h0;
		i_host.issue(w, a, dv, int'(rnd() % 3));
		chk_word(cmd_rdata, exp);
		chk_bit(cmd_hit, a == 6'h26 || a == 6'h27 || a == 6'h2c);
		if (!(w && a == 6'h26)) m1[17:16] = 2'h0;
		if (w && a == 6'h26) m1 = dv & 24'he72f9f;
		if (w && a == 6'h27) m2 = {18'h0, dv[5:3], dv[2] && (u7 || m2[2]), dv[1] && (u17 || m2[1]), 1'b0};
		if (w && a == 6'h2c) m3 = dv & 24'h1021f7;
		chk_word({6'h0, second_direction_enable, lin_stuck_transmit_detect, pump_dither_disable, pump_off,
			can_auto_bias, load_supervision_disable, watchdog_setting_unlock, watchdog_trigger,
			thermal_cluster_enable, high_side_const_current_enable}, {6'h0, !m2[5], m1[22], m1[18], m2[2],
			m1[4], m2[1], m1[16], m1[0], m3[20], m3[13], m3[8:4], m3[2:0]});
	endtask
	task chk_derived();
		logic tw, wc;
		r = rnd();
		{pwm_shared, pwm_six, shared_input_pin, can_transmit_input, can_transceiver_rx} = r[4:0];
		{thermal_warning, open_load, interface_error, phys_layer_error, warning_condition} = r[9:5];
		power_mode = door_ctrl_pkg::power_mode_t'(r[11:10] % 2'h3);
		tw = r[9];
		wc = r[5];
		repeat (6) @(posedge core_clk);
		#1;
		chk_word({half_bridge_four_ls_pwm, half_bridge_five_ls_pwm, half_bridge_six_ls_pwm, first_direction_input,
			second_external_wake_input, secondary_regulator_on, can_receive_output, 9'h0, global_status_byte},
			{r[4] && m2[3], r[4] && m2[4], r[3] && m2[5], r[2] && m1[3], r[2] && !m1[3],
			(m1[2:1] == 2'h1 && power_mode == door_ctrl_pkg::mode_active)
			|| (m1[2] && power_mode != door_ctrl_pkg::mode_battery_standby), m1[23] ? r[1] : r[0], 9'h0,
			(tw && !m1[13]) || (r[8] && !m1[11]) || (r[7] && !m1[10]) || (r[6] && !m1[9]) || (wc && !m1[8]),
			1'b0, r[7], r[6], r[8], 1'b0, tw || wc, 1'b0});
	endtask
	task lin_try(input logic edge_mode, input int n, input logic expv);
		int seen;
		do_cmd(1'b1, 6'h26, {2'h0, edge_mode, 21'h0});
		seen = 0;
		lin_bus_rx = 1'b0;
		repeat (n + 12) begin
			@(posedge core_clk);
			#1;
			if (lin_wake === 1'b1) seen++;
			lin_bus_rx = n-- <= 1;
		end
		chk_bit(seen != 0, expv);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		conclude();
	end
	initial begin
		rst = 1'b1;
		seed = 32'hb1fdb684;
		{can_transmit_input, can_transceiver_rx, shared_input_pin, pwm_shared, pwm_six} = 5'h0;
		{thermal_warning, open_load, interface_error, phys_layer_error, warning_condition} = 5'h0;
		lin_bus_rx = 1'b1;
		power_mode = door_ctrl_pkg::mode_active;
		mismatches = 0;
		n_checks = 0;
		{m1, m2, m3} = {24'h400088, 24'h0, 24'h0};
		seq = '{{1'b0, 6'h26, 24'h0}, {1'b0, 6'h27, 24'h0}, {1'b0, 6'h2c, 24'h0}, {1'b0, 6'h3f, 24'h0},
			{1'b1, 6'h26, 24'h020000}, {1'b1, 6'h27, 24'h000006}, {1'b1, 6'h27, 24'h0}, {1'b1, 6'h26, 24'h030080},
			{1'b0, 6'h26, 24'h0}, {1'b1, 6'h27, 24'h000006}, {1'b0, 6'h27, 24'h0}};
		repeat (10) @(posedge core_clk);
		#1;
		rst = 1'b0;
		chk_derived();
		foreach (seq[i]) do_cmd(seq[i][30], seq[i][29:24], seq[i][23:0]);
		$display("reset values and unlock sequence done");
		repeat (40) begin
			r = rnd();
			d = rnd();
			do_cmd(r[31] || r[30], r[1:0] == 2'h0 ? 6'h26 : r[1:0] == 2'h1 ? 6'h27 : r[1:0] == 2'h2 ? 6'h2c : r[7:2], d);
			chk_derived();
		end
		$display("random commands done");
		lin_try(1'b0, 7, 1'b0);
		lin_try(1'b0, 9, 1'b1);
		lin_try(1'b1, 3, 1'b1);
		$display("lin wake done");
		conclude();
	end
endmodule
`default_nettype wire
